/* rtl/rvtm_vector_map.sv */
// reset entry sequencer and vector address generator
// assumes program memory answers each request with one mem_rvalid pulse
// and the core holds vector_req until vector_valid
//
// Summary of operation
// - reset clears state, fetch restarts at zero
// - reset entry uses no vector lookup
// - entry is jump word then target word
// - primary traps after reserved word at 0x4
// - primary irq n at 0x14 plus 2n
// - alternate table mirrors primary from 0x100
// - alternate traps keep primary order
// - no vector lookup reaches code at 0x200
// - select bit moves all vectors to alternate
// - lowest table address wins priority
// - vector entry read as 24-bit address
`timescale 1ns/1ps
`default_nettype none
module rvtm_vector_map
	import rvtm_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic                alternate_table_select,
	input  wire logic [NUM_TRAPS-1:0] trap_req,
	input  wire logic [NUM_IRQS-1:0] irq_req,
	input  wire logic                vector_req,
	output logic                     mem_req,
	output logic [ADDR_W-1:0]        mem_addr,
	input  wire logic [ADDR_W-1:0]   mem_rdata,
	input  wire logic                mem_rvalid,
	output logic                     entry_valid,
	output logic [ADDR_W-1:0]        entry_instr,
	output logic [ADDR_W-1:0]        entry_target,
	output logic                     vector_valid,
	output logic [ADDR_W-1:0]        vector_target,
	output logic [ADDR_W-1:0]        vector_slot_addr,
	output logic [IDX_W-1:0]         vector_index,
	output logic                     vector_is_trap,
	output logic                     vector_alt
);
	rvtm_state_t             state_reg;
	logic                    found;
	logic [IDX_W-1:0]        win_index;
	logic [ADDR_W-1:0]       slot_next;
	logic [ADDR_W-1:0]       base_next;
	logic                    take;

	// traps sit below interrupts, so they fill the low slots
	rvtm_prio_enc #(.N(NUM_SLOTS), .W(IDX_W)) u_enc (
		.req   ({irq_req, trap_req}),
		.found (found),
		.index (win_index)
	);

	assign take = (state_reg == S_IDLE) && vector_req && found;
	assign mem_req = (state_reg != S_IDLE);

	always_comb begin
		base_next = alternate_table_select ? ALT_BASE : PRI_BASE;
		if (win_index < IDX_W'(NUM_TRAPS)) begin
			slot_next = base_next + TRAP_OFS
				+ WORD_STEP * ADDR_W'(win_index);
		end else begin
			slot_next = base_next + IRQ_OFS
				+ WORD_STEP * ADDR_W'(win_index - IDX_W'(NUM_TRAPS));
		end
	end

	// reset entry is a fixed walk; the encoder is never consulted
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= S_BOOT_INSTR;
		end else begin
			unique case (state_reg)
				S_BOOT_INSTR: begin
					if (mem_rvalid) state_reg <= S_BOOT_TARGET;
				end
				S_BOOT_TARGET: begin
					if (mem_rvalid) state_reg <= S_IDLE;
				end
				S_IDLE: begin
					if (take) state_reg <= S_VECTOR;
				end
				S_VECTOR: begin
					if (mem_rvalid) state_reg <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			mem_addr <= RESET_ADDR;
		end else if (state_reg == S_BOOT_INSTR && mem_rvalid) begin
			mem_addr <= BOOT_TARGET;
		end else if (take) begin
			mem_addr <= slot_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			entry_valid  <= 1'b0;
			entry_instr  <= '0;
			entry_target <= '0;
		end else begin
			entry_valid <= (state_reg == S_BOOT_TARGET) && mem_rvalid;
			if (state_reg == S_BOOT_INSTR && mem_rvalid) begin
				entry_instr <= mem_rdata;
			end
			if (state_reg == S_BOOT_TARGET && mem_rvalid) begin
				entry_target <= mem_rdata;
			end
		end
	end

	// select is sampled at take time; a change mid-fetch waits
	always_ff @(posedge mclk) begin
		if (reset) begin
			vector_slot_addr <= '0;
			vector_index     <= '0;
			vector_is_trap   <= 1'b0;
			vector_alt       <= 1'b0;
		end else if (take) begin
			vector_slot_addr <= slot_next;
			vector_index     <= win_index;
			vector_is_trap   <= win_index < IDX_W'(NUM_TRAPS);
			vector_alt       <= alternate_table_select;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			vector_valid  <= 1'b0;
			vector_target <= '0;
		end else begin
			vector_valid <= (state_reg == S_VECTOR) && mem_rvalid;
			if (state_reg == S_VECTOR && mem_rvalid) begin
				vector_target <= mem_rdata;
			end
		end
	end

	property p_reset_fetch;
		@(posedge mclk) disable iff (reset)
		$fell(reset) |-> mem_req && mem_addr == RESET_ADDR;
	endproperty
	a_reset_fetch: assert property (p_reset_fetch)
		else $error("fetch after reset not at zero");

	property p_no_vector_in_boot;
		@(posedge mclk) disable iff (reset)
		(state_reg == S_BOOT_INSTR || state_reg == S_BOOT_TARGET)
			|-> !vector_valid && !take;
	endproperty
	a_no_vector_in_boot: assert property (p_no_vector_in_boot)
		else $error("vector activity during reset entry");

	property p_entry_second_word;
		@(posedge mclk) disable iff (reset)
		(state_reg == S_BOOT_INSTR && mem_rvalid)
			|=> mem_req && mem_addr == BOOT_TARGET;
	endproperty
	a_entry_second_word: assert property (p_entry_second_word)
		else $error("second entry word not fetched at two");

	property p_trap_slot;
		@(posedge mclk) disable iff (reset)
		take && win_index < IDX_W'(NUM_TRAPS) |=>
			mem_addr == (vector_alt ? ALT_BASE : PRI_BASE) + TRAP_OFS
				+ WORD_STEP * ADDR_W'(vector_index);
	endproperty
	a_trap_slot: assert property (p_trap_slot)
		else $error("trap slot address wrong");

	property p_primary_irq;
		@(posedge mclk) disable iff (reset)
		take && !alternate_table_select && !(|trap_req) |=>
			mem_addr >= IRQ_OFS && mem_addr <= LAST_IRQ_OFS
			&& mem_addr[0] == 1'b0;
	endproperty
	a_primary_irq: assert property (p_primary_irq)
		else $error("primary interrupt slot out of range");

	property p_alt_irq;
		@(posedge mclk) disable iff (reset)
		take && alternate_table_select && !(|trap_req) |=>
			mem_addr >= ALT_BASE + IRQ_OFS
			&& mem_addr <= ALT_BASE + LAST_IRQ_OFS;
	endproperty
	a_alt_irq: assert property (p_alt_irq)
		else $error("alternate interrupt slot out of range");

	property p_alt_trap_order;
		@(posedge mclk) disable iff (reset)
		take && alternate_table_select && trap_req[0] |=>
			mem_addr == ALT_BASE + TRAP_OFS;
	endproperty
	a_alt_trap_order: assert property (p_alt_trap_order)
		else $error("alternate first trap slot wrong");

	property p_below_code;
		@(posedge mclk) disable iff (reset)
		state_reg == S_VECTOR |-> mem_addr < CODE_START;
	endproperty
	a_below_code: assert property (p_below_code)
		else $error("vector fetch reached code region");

	property p_select_moves;
		@(posedge mclk) disable iff (reset)
		take |=> (mem_addr >= ALT_BASE) == $past(alternate_table_select);
	endproperty
	a_select_moves: assert property (p_select_moves)
		else $error("table select not honoured");

	property p_lowest_wins;
		@(posedge mclk) disable iff (reset)
		take && trap_req[0] |=> vector_index == '0 && vector_is_trap;
	endproperty
	a_lowest_wins: assert property (p_lowest_wins)
		else $error("lower slot did not win");

	property p_target_returned;
		@(posedge mclk) disable iff (reset)
		(state_reg == S_VECTOR && mem_rvalid) |=>
			vector_valid && vector_target == $past(mem_rdata);
	endproperty
	a_target_returned: assert property (p_target_returned)
		else $error("vector target not returned");
endmodule
`default_nettype wire

/* shared/rvtm_pkg.sv */
// constants for the reset entry and vector address map
// assumes a 24-bit program address space, two address units per word
`default_nettype none
package rvtm_pkg;
	localparam int          ADDR_W          = 24;
	localparam int          NUM_TRAPS       = 4;
	localparam int          NUM_IRQS        = 118;
	localparam int          NUM_SLOTS       = NUM_TRAPS + NUM_IRQS;
	localparam int          IDX_W           = 7;
	localparam logic [23:0] RESET_ADDR      = 24'h00_0000;
	localparam logic [23:0] BOOT_TARGET     = 24'h00_0002;
	localparam logic [23:0] PRI_BASE        = 24'h00_0000;
	localparam logic [23:0] ALT_BASE        = 24'h00_0100;
	localparam logic [23:0] TRAP_OFS        = 24'h00_0006;
	localparam logic [23:0] IRQ_OFS         = 24'h00_0014;
	localparam logic [23:0] LAST_IRQ_OFS    = 24'h00_00FE;
	localparam logic [23:0] CODE_START      = 24'h00_0200;
	localparam logic [23:0] WORD_STEP       = 24'h00_0002;

	typedef enum logic [1:0] {
		S_BOOT_INSTR  = 2'b00,
		S_BOOT_TARGET = 2'b01,
		S_IDLE        = 2'b10,
		S_VECTOR      = 2'b11
	} rvtm_state_t;
endpackage
`default_nettype wire

/* rtl/rvtm_prio_enc.sv */
// lowest-index-wins priority encoder over the vector slots
// assumes request bits are synchronous to the caller's clock
`timescale 1ns/1ps
`default_nettype none
module rvtm_prio_enc
	import rvtm_pkg::*;
#(
	parameter int N = NUM_SLOTS,
	parameter int W = IDX_W
) (
	input  wire logic [N-1:0] req,
	output logic              found,
	output logic [W-1:0]      index
);
	always_comb begin
		found = 1'b0;
		index = '0;
		// scan downward so the lowest slot is the last to win
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = W'(i);
			end
		end
	end
endmodule
`default_nettype wire

/* verif/rvtm_mem_model.sv */
// program memory stand-in, one read open at a time
// assumes mem_req and mem_addr hold until the answer edge
`timescale 1ns/1ps
`default_nettype none
module rvtm_mem_model
	import rvtm_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic [3:0]        dly,
	input  wire logic              mem_req,
	input  wire logic [ADDR_W-1:0] mem_addr,
	output logic [ADDR_W-1:0]      mem_rdata,
	output logic                   mem_rvalid
);
	localparam logic [23:0] KEY = 24'h5A_5A5A;
	logic [3:0] wait_reg;

	// word at an address is addr ^ KEY, standing in for jump and
	// handler words loaded by software
	always_ff @(posedge mclk) begin
		mem_rvalid <= 1'b0;
		mem_rdata  <= ~mem_rdata; // between answers the last word and its inverse alternate
		wait_reg   <= 4'h0;
		if (reset) begin
			mem_rdata <= 24'h00_0000;
		end else if (mem_req && !mem_rvalid) begin
			if (wait_reg == dly) begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= mem_addr ^ KEY;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/rvtm_vector_map_tb.sv */
// self-checking bench for the reset entry and vector map
// assumes the memory model answers each read after dly cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: %h not %h", $time, a, b); end end
module rvtm_vector_map_tb;
	import rvtm_pkg::*;
	localparam logic [23:0] KEY = 24'h5A_5A5A;
	logic                 mclk = 1'b0;
	logic                 reset = 1'b1;
	logic                 alternate_table_select = 1'b0;
	logic [NUM_TRAPS-1:0] trap_req = '0;
	logic [NUM_IRQS-1:0]  irq_req = '0;
	logic                 vector_req = 1'b0;
	logic [3:0]           dly = 4'h0;
	logic                 mem_req, mem_rvalid, entry_valid, vector_valid;
	logic                 vector_is_trap, vector_alt;
	logic [ADDR_W-1:0]    mem_addr, mem_rdata, entry_instr, entry_target;
	logic [ADDR_W-1:0]    vector_target, vector_slot_addr;
	logic [IDX_W-1:0]     vector_index;
	int                   err_total = 0;
	int                   checks_done = 0;
	int                   slots[6] = '{4, 5, 57, 58, 120, 121};

	always #4 mclk = ~mclk;

	rvtm_vector_map dut (.mclk, .reset, .alternate_table_select,
		.trap_req, .irq_req, .vector_req, .mem_req, .mem_addr, .mem_rdata,
		.mem_rvalid, .entry_valid, .entry_instr, .entry_target,
		.vector_valid, .vector_target, .vector_slot_addr, .vector_index,
		.vector_is_trap, .vector_alt);
	rvtm_mem_model mem (.mclk, .reset, .dly, .mem_req, .mem_addr,
		.mem_rdata, .mem_rvalid);

	task automatic end_of_test();
		$display("mismatches %0d, checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// a vector request held through reset entry must not be served
	task automatic entry_check(input logic [3:0] d);
		int n = 0;
		logic drop = 1'b0;
		@(posedge mclk);
		dly <= d;
		reset <= 1'b1;
		vector_req <= 1'b1;
		irq_req[0] <= 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		do begin
			@(posedge mclk);
			if (drop) begin
				vector_req <= 1'b0;
				irq_req <= '0;
			end
			#1;
			n++;
			`CHK(vector_valid, 1'b0)
			`CHK(mem_addr inside {RESET_ADDR, BOOT_TARGET}, 1'b1)
			if (entry_valid !== 1'b1) `CHK(mem_req, 1'b1)
			drop = mem_rvalid === 1'b1 && mem_addr === BOOT_TARGET;
		end while (entry_valid !== 1'b1 && n < 40);
		`CHK(entry_valid, 1'b1)
		`CHK(mem_req, 1'b0)
		`CHK(entry_instr, RESET_ADDR ^ KEY)
		`CHK(entry_target, BOOT_TARGET ^ KEY)
	endtask

	// wanted slot plus the next one up, so natural order must decide;
	// select flips right after the take and must not count
	task automatic vec(input logic alt, input int slot, input logic [3:0] d);
		logic [NUM_SLOTS-1:0] r = '0;
		logic [23:0] a;
		int n = 0;
		r[slot] = 1'b1;
		if (slot < NUM_SLOTS - 1) r[slot + 1] = 1'b1;
		a = (alt ? ALT_BASE : PRI_BASE) + (slot < NUM_TRAPS ?
			TRAP_OFS + 24'(2 * slot) : IRQ_OFS + 24'(2 * (slot - NUM_TRAPS)));
		@(posedge mclk);
		dly <= d;
		alternate_table_select <= alt;
		trap_req <= r[NUM_TRAPS-1:0];
		irq_req <= r[NUM_SLOTS-1:NUM_TRAPS];
		vector_req <= 1'b1;
		@(posedge mclk);
		alternate_table_select <= ~alt;
		do begin
			@(posedge mclk);
			#1;
			n++;
			`CHK(mem_req, 1'b1)
			`CHK(mem_addr, a)
		end while (mem_rvalid !== 1'b1 && n < 40);
		@(posedge mclk);
		vector_req <= 1'b0;
		trap_req <= '0;
		irq_req <= '0;
		#1;
		`CHK(vector_valid, 1'b1)
		`CHK(mem_req, 1'b0)
		`CHK(vector_slot_addr, a)
		`CHK(vector_target, a ^ KEY)
		`CHK(vector_index, IDX_W'(slot))
		`CHK(vector_is_trap, slot < NUM_TRAPS)
		`CHK(vector_alt, alt)
		`CHK(vector_slot_addr < CODE_START, 1'b1)
	endtask

	initial begin
		entry_check(4'h2);
		for (int i = 0; i < 8; i++) vec(i >= 4, i % 4, 4'(i % 3));
		for (int j = 0; j < 12; j++) vec(j[0], slots[j / 2], 4'(j % 4));
		entry_check(4'h0);
		vec(1'b0, 4, 4'h0);
		end_of_test();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		err_total++;
		end_of_test();
	end
endmodule
`default_nettype wire
